/* File: pkg/rfs_pkg.sv */
// constants, types and register map of the regulator start-up sequencer
package rfs_pkg;
	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned OSC_LO_HZ = 500_000;
	localparam int unsigned OSC_HI_HZ = 1_000_000;
	localparam logic [6:0] OSC_LO_HALF = 7'(CLK_HZ / (2 * OSC_LO_HZ));
	localparam logic [6:0] OSC_HI_HALF = 7'(CLK_HZ / (2 * OSC_HI_HZ));
	localparam logic [8:0] DISCH_CYCLES = 9'h100;
	localparam logic [1:0] UV_TRIP_COUNT = 2'h2;
	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [3:0] REG_DELAY = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int unsigned DLY_W = 24;
	// slope compensation in tenths of A/us, indexed {freq, high, low}
	localparam logic [7:0] SLOPE_TENTHS [8] = '{8'h08, 8'h10, 8'h21, 8'h42,
		8'h11, 8'h22, 8'h43, 8'h86};
	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic por5_rise;    // supply above rising threshold, 5V set
		logic por5_fall;    // supply above falling threshold, 5V set
		logic por3_rise;    // supply above rising threshold, 3.3V set
		logic por3_fall;    // supply above falling threshold, 3.3V set
		logic en_above;     // enable comparator above threshold
		logic ramp_ref;     // ramp node at reference level
		logic ramp_top;     // ramp node at top of ramp
		logic fb_111;       // feedback above 111%
		logic fb_1075;      // feedback above 107.5%
		logic fb_925;       // feedback above 92.5%
		logic fb_89;        // feedback above 89%
		logic fb_uv;        // undervoltage comparator tripped
		logic fb_uv_hyst;   // feedback above uv threshold plus hysteresis
	} rfs_cmp_t;
	typedef struct packed {
		logic supply_threshold_select;
		logic frequency_select_strap;
		logic slope_select_high_bit;
		logic slope_select_low_bit;
	} rfs_strap_t;
	localparam int unsigned IN_W = $bits(rfs_cmp_t) + $bits(rfs_strap_t);
	typedef enum logic [5:0] {
		ST_OFF = 6'h01,
		ST_DISCH = 6'h02,
		ST_SS = 6'h04,
		ST_TAIL = 6'h08,
		ST_RUN = 6'h10,
		ST_UV_DLY = 6'h20
	} rfs_state_t;
endpackage

/* File: rtl/rfs_sequencer.sv */
// start-up, power-good and undervoltage sequencer with avalon register slave
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module rfs_sequencer #(
	parameter logic [rfs_pkg::DLY_W-1:0] DLY_DEFAULT = 24'h0186A0
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire rfs_pkg::rfs_cmp_t cmp_in,
	input wire rfs_pkg::rfs_strap_t strap_in,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic switches_on,
	output logic switch_node_output_hiz,
	output logic en_sink_on,
	output logic ramp_discharge,
	output logic output_in_window_flag_o,
	output logic output_in_window_flag_oe,
	output logic osc_out,
	output logic [7:0] slope_tenths
);
	import rfs_pkg::*;

	// -----------------------------------------------------------------
	// input synchronisers
	// -----------------------------------------------------------------
	logic [IN_W-1:0] async_in;
	logic [IN_W-1:0] sync1_r;
	logic [IN_W-1:0] sync2_r;
	logic [IN_W-1:0] sync3_r;
	logic [IN_W-1:0] filt_r;
	rfs_cmp_t c;
	rfs_strap_t s;
	assign async_in = {cmp_in, strap_in};
	assign {c, s} = filt_r;

	genvar gi;
	generate
		for (gi = 0; gi < IN_W; gi++) begin : g_sync
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync3_r[gi] <= 1'b0;
					filt_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= async_in[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
					// a change counts only once two stages agree
					if (sync2_r[gi] == sync3_r[gi]) begin
						filt_r[gi] <= sync3_r[gi];
					end
				end
			end
		end
	endgenerate

	// -----------------------------------------------------------------
	// supply valid and enable
	// -----------------------------------------------------------------
	logic supply_ok_r;
	logic sel_rise;
	logic sel_fall;
	logic en_ok;
	logic loss;
	assign sel_rise = s.supply_threshold_select ? c.por5_rise : c.por3_rise;
	assign sel_fall = s.supply_threshold_select ? c.por5_fall : c.por3_fall;
	assign en_ok = c.en_above;
	assign loss = !(supply_ok_r && en_ok);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			supply_ok_r <= 1'b0;
		end else if (sel_rise) begin
			supply_ok_r <= 1'b1;
		end else if (!sel_fall) begin
			supply_ok_r <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// switching oscillator
	// -----------------------------------------------------------------
	logic [6:0] osc_cnt_r;
	logic osc_r;
	logic osc_tick;
	logic [6:0] osc_half;
	assign osc_half = s.frequency_select_strap ? OSC_HI_HALF : OSC_LO_HALF;
	assign osc_tick = (osc_cnt_r == 7'h00) && !osc_r;

	// half-period down counter; a tick starts each switching cycle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			osc_cnt_r <= 7'h00;
			osc_r <= 1'b0;
		end else if (osc_cnt_r == 7'h00) begin
			osc_cnt_r <= osc_half - 7'h01;
			osc_r <= !osc_r;
		end else begin
			osc_cnt_r <= osc_cnt_r - 7'h01;
		end
	end

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	rfs_state_t st_r;
	logic [8:0] dis_cnt_r;
	logic [DLY_W-1:0] dly_cnt_r;
	logic [DLY_W-1:0] dly_cycles_r;
	logic [1:0] uv_cnt_r;
	logic uv_counting;
	logic uv_trip;
	logic active;
	assign uv_counting = (st_r == ST_SS) || (st_r == ST_TAIL) || (st_r == ST_RUN);
	assign uv_trip = uv_counting && osc_tick && c.fb_uv && (uv_cnt_r == UV_TRIP_COUNT - 2'h1);
	assign active = uv_counting || (st_r == ST_UV_DLY);

	// main state register; loss of supply or enable beats every fault
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_OFF;
		end else begin
			case (st_r)
				ST_OFF: begin
					if (!loss) begin
						st_r <= ST_SS;
					end
				end
				ST_DISCH: begin
					if (dis_cnt_r == 9'h000) begin
						st_r <= ST_OFF;
					end
				end
				ST_SS: begin
					if (loss) begin
						st_r <= ST_DISCH;
					end else if (uv_trip) begin
						st_r <= ST_UV_DLY;
					end else if (c.ramp_ref) begin
						st_r <= ST_TAIL;
					end
				end
				ST_TAIL: begin
					if (loss) begin
						st_r <= ST_DISCH;
					end else if (uv_trip) begin
						st_r <= ST_UV_DLY;
					end else if (c.ramp_top) begin
						st_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (loss) begin
						st_r <= ST_DISCH;
					end else if (uv_trip) begin
						st_r <= ST_UV_DLY;
					end
				end
				ST_UV_DLY: begin
					if (loss) begin
						st_r <= ST_DISCH;
					end else if (dly_cnt_r == '0) begin
						st_r <= ST_SS;
					end
				end
				default: begin
					st_r <= ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dis_cnt_r <= 9'h000;
		end else if (active && loss) begin
			dis_cnt_r <= DISCH_CYCLES - 9'h001;
		end else if ((st_r == ST_DISCH) && (dis_cnt_r != 9'h000)) begin
			dis_cnt_r <= dis_cnt_r - 9'h001;
		end
	end

	// delay interval from programmed count; zero acts as one
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dly_cnt_r <= '0;
		end else if (uv_trip) begin
			dly_cnt_r <= (dly_cycles_r == '0) ? '0 : dly_cycles_r - 1'b1;
		end else if ((st_r == ST_UV_DLY) && (dly_cnt_r != '0)) begin
			dly_cnt_r <= dly_cnt_r - 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			uv_cnt_r <= 2'h0;
		end else if (!uv_counting || uv_trip) begin
			uv_cnt_r <= 2'h0;
		end else if (osc_tick && c.fb_uv) begin
			uv_cnt_r <= uv_cnt_r + 2'h1;
		end else if (osc_tick && c.fb_uv_hyst) begin
			uv_cnt_r <= 2'h0;
		end
	end

	// -----------------------------------------------------------------
	// power-good window
	// -----------------------------------------------------------------
	logic ov_r;
	logic uvw_r;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ov_r <= 1'b0;
			uvw_r <= 1'b0;
		end else if (st_r != ST_RUN) begin
			ov_r <= 1'b0;
			uvw_r <= 1'b0;
		end else begin
			if (c.fb_111) begin
				ov_r <= 1'b1;
			end else if (!c.fb_1075) begin
				ov_r <= 1'b0;
			end
			if (!c.fb_89) begin
				uvw_r <= 1'b1;
			end else if (c.fb_925) begin
				uvw_r <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// pin outputs
	// -----------------------------------------------------------------
	logic sw_on_r;
	logic sw_hiz_r;
	logic ramp_dis_r;
	logic en_sink_r;
	logic pg_oe_r;
	logic pg_o_r;
	logic [7:0] slope_r;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sw_on_r <= 1'b0;
			sw_hiz_r <= 1'b1;
		end else begin
			sw_on_r <= supply_ok_r && uv_counting;
			sw_hiz_r <= !(supply_ok_r && uv_counting);
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ramp_dis_r <= 1'b1;
		end else begin
			ramp_dis_r <= loss || !uv_counting;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			en_sink_r <= 1'b1;
		end else begin
			en_sink_r <= !en_ok;
		end
	end

	// open drain pulls low; enable drop skips the state machine
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pg_oe_r <= 1'b1;
			pg_o_r <= 1'b0;
		end else begin
			// raw window levels also gate, so entering run cannot flash a release
			pg_oe_r <= !(st_r == ST_RUN && en_ok && !ov_r && !uvw_r && !c.fb_111
				&& c.fb_89);
			pg_o_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			slope_r <= 8'h00;
		end else begin
			slope_r <= SLOPE_TENTHS[{s.frequency_select_strap, s.slope_select_high_bit,
				s.slope_select_low_bit}];
		end
	end

	assign switches_on = sw_on_r;
	assign switch_node_output_hiz = sw_hiz_r;
	assign en_sink_on = en_sink_r;
	assign ramp_discharge = ramp_dis_r;
	assign output_in_window_flag_o = pg_o_r;
	assign output_in_window_flag_oe = pg_oe_r;
	assign osc_out = osc_r;
	assign slope_tenths = slope_r;

	// -----------------------------------------------------------------
	// avalon slave, one wait cycle per access
	// -----------------------------------------------------------------
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] status;
	assign status = {16'h0000, slope_r[7:0] == 8'h00 ? 3'h0 : {s.frequency_select_strap,
		s.slope_select_high_bit, s.slope_select_low_bit}, uv_cnt_r, uvw_r, ov_r,
		!pg_oe_r, en_ok, supply_ok_r, st_r};

	// read data latched as the wait is dropped; unmapped reads zero
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else if ((avs_read || avs_write) && wait_r) begin
			wait_r <= 1'b0;
			case (avs_address)
				REG_DELAY: rdata_r <= {{(32 - DLY_W){1'b0}}, dly_cycles_r};
				REG_STATUS: rdata_r <= status;
				default: rdata_r <= 32'h0000_0000;
			endcase
		end else begin
			wait_r <= 1'b1;
		end
	end

	// delay interval register, byte lanes honoured
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dly_cycles_r <= DLY_DEFAULT;
		end else if (avs_write && !wait_r && (avs_address == REG_DELAY)) begin
			for (int b = 0; b < DLY_W / 8; b++) begin
				if (avs_byteenable[b]) begin
					dly_cycles_r[b*8 +: 8] <= avs_writedata[b*8 +: 8];
				end
			end
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata = rdata_r;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	property p_ss_needs_supply;
		@(posedge core_clk) disable iff (!nrst)
		$rose(st_r == ST_SS) |-> $past(supply_ok_r) && $past(en_ok);
	endproperty
	a_ss_needs_supply: assert property (p_ss_needs_supply) else $error("soft-start without supply");

	property p_hiz_low_supply;
		@(posedge core_clk) disable iff (!nrst)
		!supply_ok_r |=> sw_hiz_r && !sw_on_r;
	endproperty
	a_hiz_low_supply: assert property (p_hiz_low_supply) else $error("switching without supply");

	property p_supply_hyst;
		@(posedge core_clk) disable iff (!nrst)
		supply_ok_r && sel_fall |=> supply_ok_r;
	endproperty
	a_supply_hyst: assert property (p_supply_hyst) else $error("supply dropped above fall level");

	property p_sink_off;
		@(posedge core_clk) disable iff (!nrst)
		en_ok ##1 en_ok |-> !en_sink_r;
	endproperty
	a_sink_off: assert property (p_sink_off) else $error("sink on above threshold");

	property p_disch_len;
		@(posedge core_clk) disable iff (!nrst)
		$rose(st_r == ST_DISCH) |-> ##255 (st_r == ST_DISCH) ##1 (st_r != ST_DISCH);
	endproperty
	a_disch_len: assert property (p_disch_len) else $error("discharge length wrong");

	property p_pg_before_run;
		@(posedge core_clk) disable iff (!nrst)
		(st_r != ST_RUN) |=> pg_oe_r;
	endproperty
	a_pg_before_run: assert property (p_pg_before_run) else $error("flag released early");

	property p_pg_disable;
		@(posedge core_clk) disable iff (!nrst)
		!en_ok |=> pg_oe_r;
	endproperty
	a_pg_disable: assert property (p_pg_disable) else $error("flag high after disable");

	property p_ov_hold;
		@(posedge core_clk) disable iff (!nrst)
		ov_r && c.fb_1075 && (st_r == ST_RUN) |=> ov_r;
	endproperty
	a_ov_hold: assert property (p_ov_hold) else $error("overvoltage cleared early");

	property p_uv_two;
		@(posedge core_clk) disable iff (!nrst)
		$rose(st_r == ST_UV_DLY) |-> $past(uv_cnt_r) == 2'h1;
	endproperty
	a_uv_two: assert property (p_uv_two) else $error("uv shutdown without two trips");

	property p_uv_clear;
		@(posedge core_clk) disable iff (!nrst)
		(st_r == ST_UV_DLY) |-> uv_cnt_r == 2'h0;
	endproperty
	a_uv_clear: assert property (p_uv_clear) else $error("uv counter not cleared");

	c_run: cover property (@(posedge core_clk) disable iff (!nrst) $rose(st_r == ST_RUN));
	c_uv: cover property (@(posedge core_clk) disable iff (!nrst) $rose(st_r == ST_UV_DLY));
	c_retry: cover property (@(posedge core_clk) disable iff (!nrst)
		(st_r == ST_UV_DLY) ##1 (st_r == ST_SS));
	c_disch: cover property (@(posedge core_clk) disable iff (!nrst) $fell(st_r == ST_DISCH));
endmodule // rfs_sequencer

/* File: verification/rfs_sys_ctrl.sv */
// partner model: system controller driving enable and reading power-good
`timescale 1ns/1ps
module rfs_sys_ctrl (
	input wire logic en_req,
	input wire logic flag_o,
	input wire logic flag_oe,
	output logic en_above,
	output logic pg_level
);
	// enable divider is a plain level, the comparator sees it at once
	assign en_above = en_req;
	// open-drain flag with external pull-up: released line reads high
	assign pg_level = flag_oe ? flag_o : 1'b1;
endmodule // rfs_sys_ctrl

/* File: verification/test_rfs_sequencer.sv */
// self-checking bench of the regulator start-up sequencer
`timescale 1ns/1ps
module test_rfs_sequencer;
	import rfs_pkg::*;
	typedef struct packed {
		logic [2:0] s;
		logic [7:0] slope;
		logic [7:0] per;
	} rfs_row_t;
	localparam logic [23:0] DLY = 24'h000020;
	// reset value differs from the written one, so the write is seen to land
	localparam logic [23:0] DLY_RST = 24'h000040;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	rfs_cmp_t cmp_r = '0;
	rfs_cmp_t cmp_in;
	rfs_strap_t strap_in = '0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, switches_on, switch_node_output_hiz, en_sink_on, ramp_discharge;
	logic flag_o, flag_oe, osc_out, osc_q, en_req, en_above, pg_level;
	logic [7:0] slope_tenths;
	logic [31:0] q;
	int err_total = 0;
	int cmp_count = 0;
	int n, p;
	// slope index {freq, high, low}, slope in tenths, oscillator period in clocks
	rfs_row_t rows [8] = '{'{3'h0, 8'h08, 8'h64}, '{3'h1, 8'h10, 8'h64},
		'{3'h2, 8'h21, 8'h64}, '{3'h3, 8'h42, 8'h64}, '{3'h4, 8'h11, 8'h32},
		'{3'h5, 8'h22, 8'h32}, '{3'h6, 8'h43, 8'h32}, '{3'h7, 8'h86, 8'h32}};
	// window rows {above 111, above 107.5, above 92.5, above 89, flag released}
	logic [4:0] win [6] = '{5'h1E, 5'h0E, 5'h07, 5'h00, 5'h02, 5'h07};

	// -----------------------------------------------------------------
	// clock, partner and device
	// -----------------------------------------------------------------
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) osc_q <= osc_out;
	// enable level comes from the controller model
	always_comb begin
		cmp_in = cmp_r;
		cmp_in.en_above = en_above;
	end
	initial en_req = 1'b0;
	rfs_sys_ctrl i_ctrl (.en_req(en_req), .flag_o(flag_o), .flag_oe(flag_oe),
		.en_above(en_above), .pg_level(pg_level));
	rfs_sequencer #(.DLY_DEFAULT(DLY_RST)) i_dut (.core_clk(core_clk), .nrst(nrst),
		.cmp_in(cmp_in), .strap_in(strap_in), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .switches_on(switches_on),
		.switch_node_output_hiz(switch_node_output_hiz), .en_sink_on(en_sink_on),
		.ramp_discharge(ramp_discharge), .output_in_window_flag_o(flag_o),
		.output_in_window_flag_oe(flag_oe), .osc_out(osc_out),
		.slope_tenths(slope_tenths));

	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	// one avalon cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge core_clk);
		// no limit of its own: only the watchdog ends a stalled access
		while (avs_waitrequest !== 1'b0) begin
			@(posedge core_clk);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	// bounded wait for the switches to reach a level
	task automatic wait_sw(input logic v);
		n = 0;
		while (switches_on !== v && n < 2000) begin
			@(posedge core_clk);
			n++;
		end
	endtask
	function automatic logic osc_up();
		return osc_out === 1'b1 && osc_q === 1'b0;
	endfunction
	task automatic meas_osc();
		int k;
		k = 0;
		while (!osc_up() && k < 300) begin
			@(posedge core_clk);
			k++;
		end
		@(posedge core_clk);
		p = 1;
		while (!osc_up() && p < 300) begin
			@(posedge core_clk);
			p++;
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// -----------------------------------------------------------------
	// watchdog: whole run needs well under 10000 cycles
	// -----------------------------------------------------------------
	initial begin
		cyc(20000);
		err_total++;
		give_verdict();
	end

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		cyc(3);
		chb("flag_oe", 1'b1, flag_oe);
		chb("hiz", 1'b1, switch_node_output_hiz);
		nrst <= 1'b1;
		bus(1'b0, REG_DELAY, 32'h0);
		chk("delay rst", {8'h0, DLY_RST}, q);
		bus(1'b1, REG_DELAY, {8'h0, DLY});
		bus(1'b0, REG_DELAY, 32'h0);
		chk("delay reg", {8'h0, DLY}, q);
		bus(1'b0, 4'h8, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test bus done");
		// enable without supply: no start, sink off
		en_req <= 1'b1;
		cyc(20);
		chb("switches", 1'b0, switches_on);
		chb("hiz", 1'b1, switch_node_output_hiz);
		chb("sink", 1'b0, en_sink_on);
		en_req <= 1'b0;
		cmp_r <= '{por3_rise: 1'b1, por3_fall: 1'b1, fb_925: 1'b1, fb_89: 1'b1, default: 1'b0};
		cyc(20);
		chb("sink", 1'b1, en_sink_on);
		chb("switches", 1'b0, switches_on);
		$display("test gating done");
		// start-up through ramp levels
		en_req <= 1'b1;
		wait_sw(1'b1);
		chb("start", 1'b1, n <= 10);
		cyc(1);
		chb("discharge", 1'b0, ramp_discharge);
		chb("flag_oe", 1'b1, flag_oe);
		cmp_r.ramp_ref <= 1'b1;
		cyc(10);
		chb("flag_oe", 1'b1, flag_oe);
		cmp_r.ramp_top <= 1'b1;
		cyc(10);
		chb("pg", 1'b1, pg_level);
		$display("test start done");
		// strap table
		for (int i = 0; i < 8; i++) begin
			strap_in <= '{1'b0, rows[i].s[2], rows[i].s[1], rows[i].s[0]};
			cyc(8);
			chk("slope", {24'h0, rows[i].slope}, {24'h0, slope_tenths});
			meas_osc();
			chk("osc period", {24'h0, rows[i].per}, p);
		end
		strap_in <= '0;
		cmp_r.por3_rise <= 1'b0;
		cyc(10);
		chb("switches", 1'b1, switches_on);
		$display("test straps done");
		// power-good window with hysteresis
		for (int i = 0; i < 6; i++) begin
			{cmp_r.fb_111, cmp_r.fb_1075, cmp_r.fb_925, cmp_r.fb_89} <= win[i][4:1];
			cyc(8);
			chb("pg window", win[i][0], pg_level);
		end
		$display("test window done");
		// single undervoltage detection, recovery before the next tick
		meas_osc();
		cmp_r.fb_uv <= 1'b1;
		@(posedge core_clk);
		n = 0;
		while (!osc_up() && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		bus(1'b0, REG_STATUS, 32'h0);
		chk("uv count", 32'h1, {30'h0, q[12:11]});
		cmp_r.fb_uv <= 1'b0;
		cmp_r.fb_uv_hyst <= 1'b1;
		cyc(250);
		chb("uv recover", 1'b1, switches_on);
		bus(1'b0, REG_STATUS, 32'h0);
		chk("uv cleared", 32'h0, {30'h0, q[12:11]});
		// persistent undervoltage: hiccup twice, then recover
		cmp_r.fb_uv <= 1'b1;
		cmp_r.fb_uv_hyst <= 1'b0;
		wait_sw(1'b0);
		chb("uv trip", 1'b1, n >= 95 && n <= 215);
		wait_sw(1'b1);
		chb("uv delay", 1'b1, n >= 32 && n <= 50);
		wait_sw(1'b0);
		chb("uv retry", 1'b1, n >= 95 && n <= 215);
		cmp_r.fb_uv <= 1'b0;
		cmp_r.fb_uv_hyst <= 1'b1;
		wait_sw(1'b1);
		cyc(15);
		chb("pg retry", 1'b1, pg_level);
		$display("test undervoltage done");
		// disable: flag at once, discharge lasts 256 cycles
		en_req <= 1'b0;
		cyc(7);
		chb("pg off", 1'b0, pg_level);
		chb("discharge", 1'b1, ramp_discharge);
		en_req <= 1'b1;
		wait_sw(1'b1);
		chb("discharge len", 1'b1, n + 7 >= 256 && n + 7 <= 272);
		cmp_r.por3_fall <= 1'b0;
		cyc(10);
		chb("switches", 1'b0, switches_on);
		chb("hiz", 1'b1, switch_node_output_hiz);
		$display("test disable done");
		// 5V threshold set selected by strap
		strap_in.supply_threshold_select <= 1'b1;
		cmp_r.por3_rise <= 1'b1;
		cmp_r.por3_fall <= 1'b1;
		cyc(300);
		chb("5v set", 1'b0, switches_on);
		cmp_r.por5_rise <= 1'b1;
		cmp_r.por5_fall <= 1'b1;
		wait_sw(1'b1);
		chb("5v start", 1'b1, n <= 10);
		// second reset in mid-run
		nrst <= 1'b0;
		cyc(3);
		chb("flag_oe", 1'b1, flag_oe);
		chb("switches", 1'b0, switches_on);
		nrst <= 1'b1;
		cyc(5);
		$display("test threshold and reset done");
		give_verdict();
	end
endmodule // test_rfs_sequencer
